// ### ctr_pkg.sv
// Shared constants and types for the eight-channel counter timing block.
// Assumes one 50 MHz system clock and a word-indexed register port.
package ctr_pkg;
  // ==========================================================
  // Sizes and timing.
  localparam int NCTR       = 8;
  localparam int CNT_W      = 32;
  localparam int DW         = 32;
  localparam int AW         = 8;
  localparam int TL         = 8;
  localparam int CLK_HZ     = 50_000_000;
  localparam int CLK_NS     = 20;
  localparam int TSO_MAX_NS = 26;
  localparam int TSO_CYC    = (TSO_MAX_NS / CLK_NS < 1) ? 1 :
                              TSO_MAX_NS / CLK_NS;
  localparam int MID_HZ     = 20_000_000;
  localparam int SLOW_HZ    = 100_000;
  localparam int REF_HZ     = 10_000_000;
  localparam int SLOW_DIV   = CLK_HZ / SLOW_HZ;
  localparam int MID_NUM    = MID_HZ / REF_HZ;
  localparam int MID_DEN    = CLK_HZ / REF_HZ;
  localparam int REF_TO_NS  = 1000;
  localparam int REF_TO_CYC = REF_TO_NS / CLK_NS;
  localparam int TB_LINE    = 7;
  localparam int STAR_LINE  = 6;
  // ==========================================================
  // Synchronised pin vector layout.
  localparam int P_SRC  = 0;
  localparam int P_GATE = NCTR;
  localparam int P_AUX  = 2 * NCTR;
  localparam int P_TRIG = 3 * NCTR;
  localparam int P_ARM  = P_TRIG + TL;
  localparam int P_REF  = P_ARM + 1;
  localparam int P_STAR = P_ARM + 2;
  localparam int PIN_W  = P_ARM + 3;
  // ==========================================================
  // Register map and fields.
  localparam logic [1:0]    R_CTRL   = 2'h0;
  localparam logic [1:0]    R_COUNT  = 2'h1;
  localparam logic [1:0]    R_LATCH  = 2'h2;
  localparam logic [1:0]    R_STAT   = 2'h3;
  localparam int            R_STRIDE = 4;
  localparam logic [AW-1:0] R_GCTRL  = 8'h80;
  localparam logic [AW-1:0] R_GSTAT  = 8'h81;
  localparam logic [DW-1:0] CTRL_MSK = 32'h0FFF_FFFF;
  localparam int F_SRC = 0, F_FALL = 2, F_GLVL = 3, F_GACT = 4;
  localparam int F_ALVL = 6, F_AACT = 7, F_ADIR = 9, F_UP = 10;
  localparam int F_TOG = 11, F_INV = 12, F_OEN = 13, F_GEXP = 14;
  localparam int F_HWARM = 15, F_ALINE = 16, F_AEXT = 19;
  localparam int F_GPATH = 20, F_APATH = 22, F_TLINE = 24;
  localparam int F_CONT = 27, F_ARM = 30, F_DISARM = 31;
  localparam int S_TC = 0, S_GEVT = 1, S_AEVT = 2, S_LAT = 3;
  localparam int S_RUN = 4, S_ARMED = 5;
  localparam int G_TB7 = 0, G_LOCK = 1, G_MOD = 2;
  localparam int GS_REF = 0, GS_LOCK = 1;
  localparam logic [2:0] G_RST = 3'h2;
  // ==========================================================
  // Mode encodings.
  typedef enum logic [1:0] {
    SRC_FIELD = 2'b00, SRC_MID = 2'b01, SRC_SLOW = 2'b10, SRC_PAIR = 2'b11
  } src_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_RUN = 2'b01, ACT_EVT = 2'b10, ACT_LAT = 2'b11
  } act_t;
  typedef enum logic [1:0] {
    PATH_FIELD = 2'b00, PATH_PAIR = 2'b01, PATH_TRIG = 2'b10,
    PATH_OFF = 2'b11
  } path_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_RUN = 2'b10
  } run_t;
endpackage

// ### ctr_top.sv
// Eight counter channels in fixed pairs, timebases and trigger bus clock.
// Assumes field pins and trigger lines are asynchronous to SYS_CLK.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Counter output changes within 26 ns of the detected source edge.
// - Pulse mode pulses one source period before toggle mode flips.
// - No path drives the count source out to the connector.
// - Gate works by edge or level; starts, stops, flags or latches.
// - Selected gate exports to its default line; undriven after reset.
// - Aux acts like gate and can also set count direction.
// - Terminal count on rollover; the output follows it.
// - Software picks pulse or toggle output on terminal count.
// - Output polarity selectable; output undriven until enabled.
// - Arm by software or shared hardware trigger; shared starts together.
// - Counters pair 0-1, 2-3, 4-5, 6-7 for direct links.
// - Timebases always come from the local clock.
// - Only the mid-rate timebase may drive trigger line seven.
// - Trigger line seven is undriven after reset.
// - Chassis variant locks the top timebase to the 10 MHz reference.
// - Locking on after reset, software can stop it, drops without ref.
// - Chassis variant maps trigger line six to the star trigger.
// - Results read by software; finite or continuous measurement.
// - Source counts on chosen edge, up or down.
// - Internal 100 kHz and 20 MHz timebases selectable as source.
module ctr_top (
  // Clock, reset and enable.
  input  wire logic                   SYS_CLK,
  input  wire logic                   SRST,
  input  wire logic                   CE,
  // Register port.
  input  wire logic [ctr_pkg::AW-1:0] ADDR,
  input  wire logic [ctr_pkg::DW-1:0] WR_DATA,
  input  wire logic                   WR_EN,
  input  wire logic                   RD_EN,
  output logic      [ctr_pkg::DW-1:0] RD_DATA,
  // Field inputs, per counter, and the shared arm input.
  input  wire logic [ctr_pkg::NCTR-1:0] SRC_IN,
  input  wire logic [ctr_pkg::NCTR-1:0] GATE_IN,
  input  wire logic [ctr_pkg::NCTR-1:0] AUX_IN,
  input  wire logic                     ARM_EXT_IN,
  // Trigger bus and backplane.
  input  wire logic [ctr_pkg::TL-1:0]   TRIG_IN,
  input  wire logic                     BP_REF_IN,
  input  wire logic                     STAR_IN,
  output logic                          TRIG7_OUT,
  output logic                          TRIG7_OE_N,
  // Counter and gate export pins.
  output logic      [ctr_pkg::NCTR-1:0] CTR_OUT,
  output logic      [ctr_pkg::NCTR-1:0] CTR_OE_N,
  output logic      [ctr_pkg::NCTR-1:0] GATE_EXP,
  output logic      [ctr_pkg::NCTR-1:0] GATE_EXP_OE_N,
  // Timebase status.
  output logic                          LOCKED
);
  localparam int N = ctr_pkg::NCTR;
  localparam int CW = ctr_pkg::CNT_W;
  localparam int TSO_D = ctr_pkg::TSO_CYC;

  // ==========================================================
  // State.
  typedef struct packed {
    logic [ctr_pkg::PIN_W-1:0] s1;
    logic [ctr_pkg::PIN_W-1:0] s2;
    logic [ctr_pkg::PIN_W-1:0] s3;
    logic [N-1:0][ctr_pkg::DW-1:0] ctrl;
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0][CW-1:0] lat;
    ctr_pkg::run_t [N-1:0] run;
    logic [N-1:0] g_prev, a_prev, g_on, a_on, tog, tcp;
    logic [N-1:0] e_tc, e_g, e_a, latched;
    logic [N-1:0] out, out_oe_n, gexp, gexp_oe_n;
    logic [2:0] gctrl;
    logic [2:0] mid_acc;
    logic mid_tick, mid_lvl, slow_tick;
    logic [15:0] slow_cnt;
    logic [7:0] ref_age;
    logic locked, t7, t7_oe_n;
    logic [ctr_pkg::DW-1:0] rd;
  } state_t;

  state_t st_ff, nxt_st;
  logic [ctr_pkg::PIN_W-1:0] pins;
  logic [N-1:0] step_v, roll_v, grise_v, arm_v;

  // Address of register k of counter i.
  function automatic logic [ctr_pkg::AW-1:0] raddr(input int i,
                                                   input logic [1:0] k);
    raddr = ctr_pkg::AW'(i * ctr_pkg::R_STRIDE) | {6'h00, k};
  endfunction
  // Whether a control or action is met by the selected signal.
  function automatic logic acts(input logic lvl_mode, input logic lv,
                                input logic rise);
    acts = lvl_mode ? lv : rise;
  endfunction
  // Start/stop permission of a gate-like input.
  function automatic logic run_ok(input logic [1:0] act,
                                  input logic lvl_mode, input logic lv,
                                  input logic on);
    if (act == ctr_pkg::ACT_RUN) begin
      run_ok = lvl_mode ? lv : on;
    end else begin
      run_ok = 1'b1;
    end
  endfunction
  // Selected gate or aux level over the pair link or trigger bus.
  function automatic logic pick(input logic [1:0] path, input logic fld,
                                input logic pair, input logic trg);
    unique case (ctr_pkg::path_t'(path))
      ctr_pkg::PATH_FIELD: pick = fld;
      ctr_pkg::PATH_PAIR:  pick = pair;
      ctr_pkg::PATH_TRIG:  pick = trg;
      ctr_pkg::PATH_OFF:   pick = 1'b0;
    endcase
  endfunction

  // Inputs that cross from pins are gathered for synchronisation.
  assign pins = {STAR_IN, BP_REF_IN, ARM_EXT_IN, TRIG_IN, AUX_IN,
                 GATE_IN, SRC_IN};
  // ==========================================================
  // Next-state logic.
  // Computes timebases, every counter channel and the register port.
  always_comb begin
    logic [ctr_pkg::PIN_W-1:0] lv, rise;
    logic [ctr_pkg::TL-1:0] tlv, trise;
    logic [ctr_pkg::DW-1:0] c;
    logic [CW-1:0] term, ncnt;
    logic sedge, glv, alv, grise, arise, up, step, roll, armt, swarm;
    logic present, lock;
    int p;
    nxt_st = st_ff;
    lv = st_ff.s2;
    rise = st_ff.s2 & ~st_ff.s3;
    step_v = '0;
    roll_v = '0;
    grise_v = '0;
    arm_v = '0;
    {c, term, ncnt} = '0;
    {sedge, glv, alv, grise, arise, up, step, roll, armt, swarm} = '0;
    {present, lock} = 2'h0;
    p = 0;
    // Two-stage synchronisers, third stage for edge detection.
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.rd = '0;
    tlv = lv[ctr_pkg::P_TRIG +: ctr_pkg::TL];
    trise = rise[ctr_pkg::P_TRIG +: ctr_pkg::TL];
    // Line six carries the star trigger in the chassis variant.
    if (st_ff.gctrl[ctr_pkg::G_MOD]) begin
      tlv[ctr_pkg::STAR_LINE] = lv[ctr_pkg::P_STAR];
      trise[ctr_pkg::STAR_LINE] = rise[ctr_pkg::P_STAR];
    end
    // Reference presence watchdog and lock qualification.
    if (rise[ctr_pkg::P_REF]) begin
      nxt_st.ref_age = '0;
    end else if (st_ff.ref_age < 8'(ctr_pkg::REF_TO_CYC)) begin
      nxt_st.ref_age = st_ff.ref_age + 8'h01;
    end
    present = st_ff.ref_age < 8'(ctr_pkg::REF_TO_CYC);
    lock = st_ff.gctrl[ctr_pkg::G_LOCK] & st_ff.gctrl[ctr_pkg::G_MOD]
           & present;
    nxt_st.locked = lock;
    // Mid-rate tick from the local clock; the reference only aligns phase.
    if (lock && rise[ctr_pkg::P_REF]) begin
      nxt_st.mid_acc = '0;
      nxt_st.mid_tick = 1'b1;
    end else if (st_ff.mid_acc + 3'(ctr_pkg::MID_NUM)
                 >= 3'(ctr_pkg::MID_DEN)) begin
      nxt_st.mid_acc = st_ff.mid_acc + 3'(ctr_pkg::MID_NUM)
                       - 3'(ctr_pkg::MID_DEN);
      nxt_st.mid_tick = 1'b1;
    end else begin
      nxt_st.mid_acc = st_ff.mid_acc + 3'(ctr_pkg::MID_NUM);
      nxt_st.mid_tick = 1'b0;
    end
    nxt_st.mid_lvl = st_ff.mid_lvl ^ st_ff.mid_tick;
    // Slow timebase divider.
    nxt_st.slow_tick = (st_ff.slow_cnt == 16'(ctr_pkg::SLOW_DIV - 1));
    nxt_st.slow_cnt = nxt_st.slow_tick ? '0 : st_ff.slow_cnt + 16'h0001;
    // Only the mid-rate level can reach trigger line seven.
    nxt_st.t7 = st_ff.mid_lvl;
    nxt_st.t7_oe_n = ~st_ff.gctrl[ctr_pkg::G_TB7];
    // Counter channels.
    for (int i = 0; i < N; i++) begin
      p = i ^ 1;
      c = st_ff.ctrl[i];
      unique case (ctr_pkg::src_t'(c[ctr_pkg::F_SRC +: 2]))
        ctr_pkg::SRC_FIELD: sedge = c[ctr_pkg::F_FALL] ?
          (~lv[ctr_pkg::P_SRC + i] & st_ff.s3[ctr_pkg::P_SRC + i]) :
          rise[ctr_pkg::P_SRC + i];
        ctr_pkg::SRC_MID:   sedge = st_ff.mid_tick;
        ctr_pkg::SRC_SLOW:  sedge = st_ff.slow_tick;
        ctr_pkg::SRC_PAIR:  sedge = st_ff.tcp[p];
      endcase
      glv = pick(c[ctr_pkg::F_GPATH +: 2], lv[ctr_pkg::P_GATE + i],
                 st_ff.out[p], tlv[c[ctr_pkg::F_TLINE +: 3]]);
      alv = pick(c[ctr_pkg::F_APATH +: 2], lv[ctr_pkg::P_AUX + i],
                 st_ff.out[p], tlv[c[ctr_pkg::F_TLINE +: 3]]);
      grise = glv & ~st_ff.g_prev[i];
      arise = alv & ~st_ff.a_prev[i];
      nxt_st.g_prev[i] = glv;
      nxt_st.a_prev[i] = alv;
      // Edge-mode start/stop toggles the permission.
      if (c[ctr_pkg::F_GACT +: 2] == ctr_pkg::ACT_RUN && grise) begin
        nxt_st.g_on[i] = ~st_ff.g_on[i];
      end
      if (c[ctr_pkg::F_AACT +: 2] == ctr_pkg::ACT_RUN && arise) begin
        nxt_st.a_on[i] = ~st_ff.a_on[i];
      end
      up = c[ctr_pkg::F_ADIR] ? alv : c[ctr_pkg::F_UP];
      term = up ? {CW{1'b1}} : {CW{1'b0}};
      // Arm by software or by the shared hardware trigger.
      swarm = WR_EN && ADDR == raddr(i, ctr_pkg::R_CTRL)
              && WR_DATA[ctr_pkg::F_ARM];
      armt = c[ctr_pkg::F_AEXT] ? rise[ctr_pkg::P_ARM] :
             trise[c[ctr_pkg::F_ALINE +: 3]];
      step = st_ff.run[i] == ctr_pkg::ST_RUN && sedge
             && run_ok(c[ctr_pkg::F_GACT +: 2], c[ctr_pkg::F_GLVL], glv,
                       st_ff.g_on[i])
             && run_ok(c[ctr_pkg::F_AACT +: 2], c[ctr_pkg::F_ALVL], alv,
                       st_ff.a_on[i]);
      roll = step && st_ff.cnt[i] == term;
      ncnt = step ? (up ? st_ff.cnt[i] + 1'b1 : st_ff.cnt[i] - 1'b1) :
             st_ff.cnt[i];
      step_v[i] = step;
      roll_v[i] = roll;
      grise_v[i] = grise;
      arm_v[i] = armt;
      unique case (st_ff.run[i])
        ctr_pkg::ST_IDLE: if (swarm) begin
          nxt_st.run[i] = c[ctr_pkg::F_HWARM] ? ctr_pkg::ST_ARMED :
                          ctr_pkg::ST_RUN;
          nxt_st.g_on[i] = 1'b0;
          nxt_st.a_on[i] = 1'b0;
        end
        ctr_pkg::ST_ARMED: if (armt) begin
          nxt_st.run[i] = ctr_pkg::ST_RUN;
        end
        ctr_pkg::ST_RUN: if (roll && !c[ctr_pkg::F_CONT]) begin
          nxt_st.run[i] = ctr_pkg::ST_IDLE;
        end
        default: nxt_st.run[i] = ctr_pkg::ST_IDLE;
      endcase
      if (WR_EN && ADDR == raddr(i, ctr_pkg::R_CTRL)
          && WR_DATA[ctr_pkg::F_DISARM]) begin
        nxt_st.run[i] = ctr_pkg::ST_IDLE;
      end
      nxt_st.cnt[i] = ncnt;
      nxt_st.tog[i] = st_ff.tog[i] ^ roll;
      nxt_st.tcp[i] = roll;
      // Pulse while at terminal value; toggle flips at the rollover.
      nxt_st.out[i] = c[ctr_pkg::F_INV] ^ (c[ctr_pkg::F_TOG] ?
        (st_ff.tog[i] ^ roll) :
        (nxt_st.run[i] == ctr_pkg::ST_RUN && ncnt == term));
      nxt_st.out_oe_n[i] = ~c[ctr_pkg::F_OEN];
      // Gate export carries the selected gate, never the count source.
      nxt_st.gexp[i] = glv;
      nxt_st.gexp_oe_n[i] = ~c[ctr_pkg::F_GEXP];
      // Register reads and writes, sticky flags with set priority.
      if (RD_EN && ADDR == raddr(i, ctr_pkg::R_LATCH)) begin
        nxt_st.latched[i] = 1'b0;
      end
      if (WR_EN && ADDR == raddr(i, ctr_pkg::R_STAT)) begin
        nxt_st.e_tc[i] = st_ff.e_tc[i] & ~WR_DATA[ctr_pkg::S_TC];
        nxt_st.e_g[i] = st_ff.e_g[i] & ~WR_DATA[ctr_pkg::S_GEVT];
        nxt_st.e_a[i] = st_ff.e_a[i] & ~WR_DATA[ctr_pkg::S_AEVT];
      end
      if (roll) begin
        nxt_st.e_tc[i] = 1'b1;
      end
      if (c[ctr_pkg::F_GACT +: 2] == ctr_pkg::ACT_EVT
          && acts(c[ctr_pkg::F_GLVL], glv, grise)) begin
        nxt_st.e_g[i] = 1'b1;
      end
      if (c[ctr_pkg::F_AACT +: 2] == ctr_pkg::ACT_EVT
          && acts(c[ctr_pkg::F_ALVL], alv, arise)) begin
        nxt_st.e_a[i] = 1'b1;
      end
      if ((c[ctr_pkg::F_GACT +: 2] == ctr_pkg::ACT_LAT
           && acts(c[ctr_pkg::F_GLVL], glv, grise))
          || (c[ctr_pkg::F_AACT +: 2] == ctr_pkg::ACT_LAT
           && acts(c[ctr_pkg::F_ALVL], alv, arise))) begin
        nxt_st.lat[i] = st_ff.cnt[i];
        nxt_st.latched[i] = 1'b1;
      end
      if (WR_EN && ADDR == raddr(i, ctr_pkg::R_CTRL)) begin
        nxt_st.ctrl[i] = WR_DATA & ctr_pkg::CTRL_MSK;
      end
      if (WR_EN && ADDR == raddr(i, ctr_pkg::R_COUNT)) begin
        nxt_st.cnt[i] = WR_DATA;
      end
      if (RD_EN && ADDR == raddr(i, ctr_pkg::R_CTRL)) begin
        nxt_st.rd = c;
      end
      if (RD_EN && ADDR == raddr(i, ctr_pkg::R_COUNT)) begin
        nxt_st.rd = st_ff.cnt[i];
      end
      if (RD_EN && ADDR == raddr(i, ctr_pkg::R_LATCH)) begin
        nxt_st.rd = st_ff.lat[i];
      end
      if (RD_EN && ADDR == raddr(i, ctr_pkg::R_STAT)) begin
        nxt_st.rd[ctr_pkg::S_TC] = st_ff.e_tc[i];
        nxt_st.rd[ctr_pkg::S_GEVT] = st_ff.e_g[i];
        nxt_st.rd[ctr_pkg::S_AEVT] = st_ff.e_a[i];
        nxt_st.rd[ctr_pkg::S_LAT] = st_ff.latched[i];
        nxt_st.rd[ctr_pkg::S_RUN] = st_ff.run[i] == ctr_pkg::ST_RUN;
        nxt_st.rd[ctr_pkg::S_ARMED] = st_ff.run[i] == ctr_pkg::ST_ARMED;
      end
    end
    // Global control and status.
    if (WR_EN && ADDR == ctr_pkg::R_GCTRL) begin
      nxt_st.gctrl = WR_DATA[2:0];
    end
    if (RD_EN && ADDR == ctr_pkg::R_GCTRL) begin
      nxt_st.rd[2:0] = st_ff.gctrl;
    end
    if (RD_EN && ADDR == ctr_pkg::R_GSTAT) begin
      nxt_st.rd[ctr_pkg::GS_REF] = present;
      nxt_st.rd[ctr_pkg::GS_LOCK] = st_ff.locked;
    end
  end

  // ==========================================================
  // State register with synchronous reset and clock enable.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_ff <= '0;
      st_ff.out_oe_n <= '1;
      st_ff.gexp_oe_n <= '1;
      st_ff.t7_oe_n <= 1'b1;
      st_ff.gctrl <= ctr_pkg::G_RST;
      st_ff.ref_age <= 8'(ctr_pkg::REF_TO_CYC);
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register.
  assign RD_DATA = st_ff.rd;
  assign TRIG7_OUT = st_ff.t7;
  assign TRIG7_OE_N = st_ff.t7_oe_n;
  assign CTR_OUT = st_ff.out;
  assign CTR_OE_N = st_ff.out_oe_n;
  assign GATE_EXP = st_ff.gexp;
  assign GATE_EXP_OE_N = st_ff.gexp_oe_n;
  assign LOCKED = st_ff.locked;

  // ==========================================================
  // Checks on counter 0 and the shared timebase logic.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_roll_toggle;
    CE && roll_v[0] && st_ff.ctrl[0][ctr_pkg::F_TOG];
  endsequence

  chk_out_delay_step: assert property (
    CE && step_v[0] |-> ##[1:TSO_D] st_ff.cnt[0] != $past(st_ff.cnt[0]))
    else $error("count did not follow the source edge in time");
  chk_toggle_on_roll: assert property (
    s_roll_toggle |=> CTR_OUT[0] != $past(CTR_OUT[0]))
    else $error("toggle output missed a rollover");
  chk_pulse_before: assert property (
    CE && roll_v[0] && !st_ff.ctrl[0][ctr_pkg::F_TOG]
    && st_ff.ctrl[0][ctr_pkg::F_CONT]
    |-> CTR_OUT[0] == ~st_ff.ctrl[0][ctr_pkg::F_INV])
    else $error("pulse not present in the period before rollover");
  chk_out_oe_idle: assert property (
    !st_ff.ctrl[0][ctr_pkg::F_OEN] && !$past(st_ff.ctrl[0][ctr_pkg::F_OEN])
    |-> CTR_OE_N[0])
    else $error("output driven while not enabled");
  chk_tb7_undriven: assert property (
    !st_ff.gctrl[ctr_pkg::G_TB7] ##1 !st_ff.gctrl[ctr_pkg::G_TB7]
    |-> TRIG7_OE_N)
    else $error("trigger line seven driven while disabled");
  chk_lock_drop: assert property (
    st_ff.ref_age == 8'(ctr_pkg::REF_TO_CYC) ##1 CE |-> !LOCKED)
    else $error("lock held without reference");
  chk_hw_arm_start: assert property (
    CE && st_ff.run[0] == ctr_pkg::ST_ARMED && arm_v[0]
    && !(WR_EN && ADDR == raddr(0, ctr_pkg::R_CTRL))
    |=> st_ff.run[0] == ctr_pkg::ST_RUN)
    else $error("armed counter ignored its arm trigger");
  chk_finite_stop: assert property (
    CE && roll_v[0] && !st_ff.ctrl[0][ctr_pkg::F_CONT]
    |=> (st_ff.run[0] == ctr_pkg::ST_IDLE) [*2])
    else $error("finite measurement kept running");
  chk_gate_latch: assert property (
    CE && grise_v[0] && !st_ff.ctrl[0][ctr_pkg::F_GLVL]
    && st_ff.ctrl[0][ctr_pkg::F_GACT +: 2] == ctr_pkg::ACT_LAT
    |=> st_ff.lat[0] == $past(st_ff.cnt[0]) && st_ff.latched[0])
    else $error("gate edge did not latch the count");
endmodule
`default_nettype wire

// ### field_peer.sv
// Model of the field side: one count source line and the backplane clock.
// Assumes the bench clock drives it and requests come one at a time.
`timescale 1ns/100ps
`default_nettype none
module field_peer (
  // Clock and controls.
  input  wire logic clk,
  input  wire logic pulse_req,
  input  wire logic ref_on,
  // Field lines.
  output logic      src_out,
  output logic      ref_out
);
  logic [2:0] hold;
  initial begin
    hold = 3'h0;
    src_out = 1'b0;
    ref_out = 1'b0;
  end
  // ==========================================================
  // One request gives a high phase of four cycles, so the edges stay wide.
  always @(posedge clk) begin
    if (pulse_req) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
    src_out <= pulse_req || (hold > 3'h1);
  end
  // The reference runs at 10 MHz; when absent the line rests low.
  always begin
    #50;
    ref_out <= ref_on ? ~ref_out : 1'b0;
  end
endmodule
`default_nettype wire

// ### paired_counter_trigger_timing_tb.sv
// Self-checking bench for the counter block through its register port.
// Assumes field_peer supplies the source pulses and the reference clock.
`timescale 1ns/100ps
`default_nettype none
module paired_counter_trigger_timing_tb;
  logic        clk, srst, wr, rd, star, preq, ref_on, src1, bpref, ce;
  logic        trig7, trig7_oe_n, locked;
  logic [7:0]  addr, trig, ctr_out, ctr_oe_n, gexp, gexp_oe_n;
  logic [31:0] wdata, rdata;
  int          mismatches, n_tests;
  ctr_top dut (.SYS_CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr),
    .WR_DATA(wdata), .WR_EN(wr), .RD_EN(rd), .RD_DATA(rdata),
    .SRC_IN({5'h00, {3{src1}}}), .GATE_IN(8'h00), .AUX_IN(8'h00),
    .ARM_EXT_IN(1'b0), .TRIG_IN(trig), .BP_REF_IN(bpref), .STAR_IN(star),
    .TRIG7_OUT(trig7), .TRIG7_OE_N(trig7_oe_n), .CTR_OUT(ctr_out),
    .CTR_OE_N(ctr_oe_n), .GATE_EXP(gexp), .GATE_EXP_OE_N(gexp_oe_n),
    .LOCKED(locked));
  field_peer peer (.clk(clk), .pulse_req(preq), .ref_on(ref_on),
    .src_out(src1), .ref_out(bpref));
  // ==========================================================
  // The clock toggles every half period of 10 ns.
  always #10 clk = ~clk;
  // Compare, count and report.
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A write is one strobe cycle; the strobe is held until the next edge.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // A read takes the data in the cycle after the strobe.
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, rdata, exp);
  endtask
  // One source request, then time for the synchronised edge to land.
  task automatic src_pulse();
    @(posedge clk);
    preq <= 1'b1;
    @(posedge clk);
    preq <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // ==========================================================
  // Reset leaves every driver off and the lock enable set.
  task automatic t_reset();
    chk("ctr oe", ctr_oe_n, 8'hFF);
    chk("gate oe", gexp_oe_n, 8'hFF);
    chk("trig7 oe", trig7_oe_n, 1'b1);
    rchk("gctrl", 8'h80, 32'h2);
    rchk("unmapped", 8'h90, 32'h0);
  endtask
  // Three counters from one source: pulse, toggle and inverted pulse.
  task automatic t_output();
    logic [2:0] exp [3];
    exp = '{3'b100, 3'b001, 3'b110};
    for (int i = 0; i < 3; i++) begin
      wreg(8'(i * 4 + 1), 32'hFFFF_FFFD);
    end
    wreg(8'h00, 32'h4800_2400);
    wreg(8'h04, 32'h4800_2C00);
    wreg(8'h08, 32'h4800_3400);
    rchk("ctrl1", 8'h04, 32'h0800_2C00);
    for (int k = 0; k < 3; k++) begin
      src_pulse();
      chk("ctr out", ctr_out[2:0], exp[k]);
    end
    chk("ctr oe on", ctr_oe_n, 8'hF8);
    rchk("count0", 8'h01, 32'h0);
  endtask
  // The shared clock line carries the 20 MHz rate only.
  task automatic t_trig7();
    int n;
    logic prev;
    n = 0;
    wreg(8'h80, 32'h3);
    repeat (3) @(posedge clk);
    chk("trig7 drive", trig7_oe_n, 1'b0);
    prev = trig7;
    repeat (50) begin
      @(posedge clk);
      if (trig7 !== prev) n++;
      prev = trig7;
    end
    chk("trig7 rate", (n >= 18 && n <= 22), 1'b1);
  endtask
  // Lock follows the reference and the software enable.
  task automatic t_lock();
    ref_on <= 1'b1;
    wreg(8'h80, 32'h6);
    repeat (100) @(posedge clk);
    chk("locked", locked, 1'b1);
    rchk("gstat", 8'h81, 32'h3);
    ref_on <= 1'b0;
    repeat (120) @(posedge clk);
    chk("ref lost", locked, 1'b0);
    ref_on <= 1'b1;
    repeat (100) @(posedge clk);
    chk("relock", locked, 1'b1);
    wreg(8'h80, 32'h4);
    repeat (5) @(posedge clk);
    chk("lock off", locked, 1'b0);
  endtask
  // Line six is the star trigger only in the chassis variant.
  task automatic t_star();
    wreg(8'h0C, 32'h0620_4000);
    star <= 1'b1;
    trig <= 8'h00;
    repeat (8) @(posedge clk);
    chk("star gate", gexp[3], 1'b1);
    chk("gate oe on", gexp_oe_n, 8'hF7);
    wreg(8'h80, 32'h0);
    repeat (8) @(posedge clk);
    chk("line6 gate", gexp[3], 1'b0);
  endtask
  // Counter 0 counts falling edges down from two, freezes while the
  // enable is low, stops at rollover, then latches on a trigger edge.
  task automatic t_finite();
    wreg(8'h00, 32'h8000_2004);
    wreg(8'h01, 32'h0000_0002);
    wreg(8'h00, 32'h4000_2004);
    ce <= 1'b0;
    src_pulse();
    ce <= 1'b1;
    rchk("frozen", 8'h01, 32'h0000_0002);
    src_pulse();
    chk("down one", ctr_out[0], 1'b0);
    src_pulse();
    chk("at zero", ctr_out[0], 1'b1);
    src_pulse();
    rchk("finite stat", 8'h03, 32'h0000_0001);
    src_pulse();
    rchk("stopped", 8'h01, 32'hFFFF_FFFF);
    wreg(8'h03, 32'h0000_0001);
    rchk("stat clear", 8'h03, 32'h0000_0000);
    wreg(8'h00, 32'h0120_0030);
    @(posedge clk);
    trig <= 8'h02;
    repeat (8) @(posedge clk);
    rchk("latched", 8'h03, 32'h0000_0008);
    rchk("latch", 8'h02, 32'hFFFF_FFFF);
    rchk("latch clear", 8'h03, 32'h0000_0000);
  endtask
  // ==========================================================
  // The verdict ends the run.
  task automatic results();
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
  // Main sequence.
  initial begin
    {clk, wr, rd, star, preq, ref_on, addr, trig, wdata} = '0;
    ce = 1'b1;
    mismatches = 0;
    n_tests = 0;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_output();
    t_trig7();
    t_lock();
    t_star();
    t_finite();
    results();
  end
endmodule
`default_nettype wire
